// ===== inc/cocfg_consts.svh
// constants for the code option configuration loader
// What this block does
// - rc clock frees oscillator pin as port1_bit2
// - always-on watchdog runs in every mode
// - enable: run normally, halt in sleep; disable: off
// - instruction cycle is 1, 2, 4 or 8 clocks
// - filter on limits divider to 4 through 8
// - reset pin is reset or input-only port0_bit2
// - security option turns rom protection on
// - low or mid level resets below 2.0V
// - mid level enables 2.4V indicator bit
// - high level resets below 2.4V, 3.6V indicator
// - slow mode cycle is low clock over four
// - bank 0: ram below 080h, system registers above
// - bank 15 holds 32 bytes of lcd ram
`ifndef COCFG_CONSTS_SVH
`define COCFG_CONSTS_SVH
// ----------------------------------------
// option encodings
// ----------------------------------------
`define COCFG_HCLK_RC       2'h0
`define COCFG_HCLK_X12M     2'h1
`define COCFG_HCLK_X4M      2'h2
`define COCFG_WDT_ALWAYS    2'h0
`define COCFG_WDT_ENABLE    2'h1
`define COCFG_WDT_DISABLE   2'h2
`define COCFG_LV_LOW        2'h0
`define COCFG_LV_MID        2'h1
`define COCFG_LV_HIGH       2'h2
// ----------------------------------------
// divider settings, as log2 of the cycle length
// ----------------------------------------
`define COCFG_DIV1          2'h0
`define COCFG_DIV2          2'h1
`define COCFG_DIV4          2'h2
`define COCFG_DIV8          2'h3
`define COCFG_SLOW_DIV      2'h2
// ----------------------------------------
// data memory map
// ----------------------------------------
`define COCFG_RAM_LAST      8'h7F
`define COCFG_SYS_FIRST     8'h80
`define COCFG_LCD_BANK      4'hF
`define COCFG_LCD_LAST      8'h1F
`endif

// ===== inc/cocfg_pkg.sv
// types of the code option configuration loader
`default_nettype none
package cocfg_pkg;
  // region that a data address falls into
  typedef enum logic [3:0] {
    COCFG_RGN_NONE = 4'b0001,
    COCFG_RGN_RAM  = 4'b0010,
    COCFG_RGN_SYS  = 4'b0100,
    COCFG_RGN_LCD  = 4'b1000
  } cocfg_rgn_e;
endpackage
`default_nettype wire

// ===== src/cocfg_clkdiv.sv
// instruction clock enable divider
`timescale 1ns/1ps
`default_nettype none
`include "cocfg_consts.svh"
module cocfg_clkdiv (
  input  wire logic       clk_in,       // high oscillator clock
  input  wire logic       srst_in,      // sync reset
  input  wire logic       slow_tick_in, // low oscillator tick
  input  wire logic       slow_in,      // running from low clock
  input  wire logic [1:0] div_log2_in,  // high-clock divide, log2
  output logic            cyc_en_out    // one instruction cycle pulse
);
  // ----------------------------------------
  // counter
  // ----------------------------------------
  logic [2:0] cnt_q;  // periods so far
  logic [2:0] cnt_d;
  logic [2:0] last;   // terminal count
  logic       tick;   // counted event
  logic       en_d;
  logic       en_q;

  // next value: count ticks up to the selected length
  always_comb begin
    tick  = slow_in ? slow_tick_in : 1'b1;
    // slow mode ignores the option, fixed divide by four
    last  = slow_in ? 3'(4'((1 << `COCFG_SLOW_DIV) - 1)) :
                      3'(4'((1 << div_log2_in) - 1));
    cnt_d = cnt_q;
    en_d  = 1'b0;
    if (tick) begin
      if (cnt_q >= last) begin
        cnt_d = 3'h0;
        en_d  = 1'b1;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_q <= 3'h0;
      en_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      en_q  <= en_d;
    end
  end

  assign cyc_en_out = en_q;
endmodule // cocfg_clkdiv
`default_nettype wire

// ===== src/cocfg_memmap.sv
// data memory address decoder
`timescale 1ns/1ps
`default_nettype none
`include "cocfg_consts.svh"
module cocfg_memmap (
  input  wire logic [3:0]         bank_in,  // data bank
  input  wire logic [7:0]         addr_in,  // address in bank
  output cocfg_pkg::cocfg_rgn_e   rgn_out   // decoded region
);
  import cocfg_pkg::*;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  always_comb begin
    rgn_out = COCFG_RGN_NONE;
    if (bank_in == 4'h0) begin
      // low half plain ram, upper half system registers
      rgn_out = (addr_in <= `COCFG_RAM_LAST) ? COCFG_RGN_RAM : COCFG_RGN_SYS;
    end else if (bank_in == `COCFG_LCD_BANK && addr_in <= `COCFG_LCD_LAST) begin
      rgn_out = COCFG_RGN_LCD;
    end
  end
endmodule // cocfg_memmap
`default_nettype wire

// ===== src/cocfg_top.sv
// code option loader: captures options and drives static controls
`timescale 1ns/1ps
`default_nettype none
`include "cocfg_consts.svh"
module cocfg_top (
  input  wire logic       clk_in,            // 100 MHz core clock
  input  wire logic       srst_in,           // sync reset, active high
  // option words
  input  wire logic [1:0] opt_hclk_in,       // high clock source
  input  wire logic [1:0] opt_wdt_in,        // watchdog policy
  input  wire logic [1:0] opt_div_in,        // instruction divider
  input  wire logic       opt_filter_in,     // noise filter
  input  wire logic       opt_rst_pin_in,    // 1: reset pin, 0: port
  input  wire logic       opt_secure_in,     // rom security
  input  wire logic [1:0] opt_lv_in,         // low voltage level
  // chip state
  input  wire logic       sleep_in,          // power-down or green
  input  wire logic       slow_in,           // slow mode
  input  wire logic       slow_tick_in,      // low clock tick
  input  wire logic       below_2v0_in,      // detector: below 2.0V
  input  wire logic       below_2v4_in,      // detector: below 2.4V
  input  wire logic [3:0] bank_in,           // data bank
  input  wire logic [7:0] addr_in,           // data address
  // controls
  output logic            osc_pin_port_out,  // osc output pin is port1_bit2
  output logic            rst_pin_port_out,  // reset pin is port0_bit2
  output logic            port0_bit2_pull_out, // pull-up allowed
  output logic            wdt_run_out,       // watchdog may count
  output logic            rom_protect_out,   // rom protection active
  output logic            lv_reset_out,      // low voltage chip reset
  output logic            ind_2v4_en_out,    // supply_2v4_indicator enable
  output logic            ind_3v6_en_out,    // supply_3v6_indicator enable
  output logic            cfg_err_out,       // illegal filter/divider pair
  output logic [1:0]      div_eff_out,       // divider in force
  output logic            cyc_en_out,        // instruction cycle enable
  output cocfg_pkg::cocfg_rgn_e rgn_out      // region of addr_in
);
  import cocfg_pkg::*;

  // ----------------------------------------
  // option capture
  // ----------------------------------------
  // options are only sampled while reset holds, so a glitch on the
  // option inputs while running cannot change the chip
  logic [1:0] hclk_q, hclk_d;
  logic [1:0] wdt_q, wdt_d;
  logic [1:0] div_q, div_d;
  logic [1:0] lv_q, lv_d;
  logic       filt_q, filt_d;
  logic       rpin_q, rpin_d;
  logic       sec_q, sec_d;
  logic       err_q, err_d;

  // next values: follow inputs only during reset
  always_comb begin
    hclk_d = hclk_q;
    wdt_d  = wdt_q;
    div_d  = div_q;
    lv_d   = lv_q;
    filt_d = filt_q;
    rpin_d = rpin_q;
    sec_d  = sec_q;
    err_d  = err_q;
    if (srst_in) begin
      hclk_d = opt_hclk_in;
      wdt_d  = opt_wdt_in;
      lv_d   = opt_lv_in;
      filt_d = opt_filter_in;
      rpin_d = opt_rst_pin_in;
      sec_d  = opt_secure_in;
      // filter on with divide 1 or 2 is a bad option word
      err_d  = opt_filter_in && (opt_div_in < `COCFG_DIV4);
      // clamp to divide-by-4 so the part still runs safely
      div_d  = err_d ? `COCFG_DIV4 : opt_div_in;
    end
  end

  // registers only
  always_ff @(posedge clk_in) begin
    hclk_q <= hclk_d;
    wdt_q  <= wdt_d;
    div_q  <= div_d;
    lv_q   <= lv_d;
    filt_q <= filt_d;
    rpin_q <= rpin_d;
    sec_q  <= sec_d;
    err_q  <= err_d;
  end

  // ----------------------------------------
  // output controls
  // ----------------------------------------
  logic osc_d, osc_q, rp_d, rp_q, wd_d, wd_q, rom_d, rom_q;
  logic lvr_d, lvr_q, i24_d, i24_q, i36_d, i36_q;

  // next values of static controls
  always_comb begin
    osc_d = (hclk_q == `COCFG_HCLK_RC);
    rp_d  = ~rpin_q;
    // watchdog policy
    case (wdt_q)
      `COCFG_WDT_ALWAYS: wd_d = 1'b1;
      `COCFG_WDT_ENABLE: wd_d = ~sleep_in;
      default:           wd_d = 1'b0;
    endcase
    rom_d = sec_q;
    // level options
    case (lv_q)
      `COCFG_LV_LOW: begin
        lvr_d = below_2v0_in;
        i24_d = 1'b0;
        i36_d = 1'b0;
      end
      `COCFG_LV_MID: begin
        lvr_d = below_2v0_in;
        i24_d = 1'b1;
        i36_d = 1'b0;
      end
      `COCFG_LV_HIGH: begin
        lvr_d = below_2v4_in;
        i24_d = 1'b0;
        i36_d = 1'b1;
      end
      default: begin
        // unused code resets below 2.4V like the strictest level, with both indicators off
        lvr_d = below_2v4_in;
        i24_d = 1'b0;
        i36_d = 1'b0;
      end
    endcase
  end

  // registers; during reset hold safe values
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      osc_q <= 1'b0;
      rp_q  <= 1'b0;
      wd_q  <= 1'b0;
      rom_q <= 1'b1; // protection on until options settle
      lvr_q <= 1'b0;
      i24_q <= 1'b0;
      i36_q <= 1'b0;
    end else begin
      osc_q <= osc_d;
      rp_q  <= rp_d;
      wd_q  <= wd_d;
      rom_q <= rom_d;
      lvr_q <= lvr_d;
      i24_q <= i24_d;
      i36_q <= i36_d;
    end
  end

  assign osc_pin_port_out    = osc_q;
  assign rst_pin_port_out    = rp_q;
  assign port0_bit2_pull_out = 1'b0;
  assign wdt_run_out         = wd_q;
  assign rom_protect_out     = rom_q;
  assign lv_reset_out        = lvr_q;
  assign ind_2v4_en_out      = i24_q;
  assign ind_3v6_en_out      = i36_q;
  assign cfg_err_out         = err_q;
  assign div_eff_out         = div_q;

  // ----------------------------------------
  // instruction clock and memory map
  // ----------------------------------------
  cocfg_clkdiv u_div (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .slow_tick_in (slow_tick_in),
    .slow_in      (slow_in),
    .div_log2_in  (div_q),
    .cyc_en_out   (cyc_en_out)
  );

  cocfg_memmap u_map (
    .bank_in (bank_in),
    .addr_in (addr_in),
    .rgn_out (rgn_out)
  );
endmodule // cocfg_top
`default_nettype wire

// ===== tb/cocfg_properties.sv
// port assertions for the code option loader
`timescale 1ns/1ps
`default_nettype none
`include "cocfg_consts.svh"
module cocfg_properties
  import cocfg_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire logic [1:0] opt_hclk_in,
  input wire logic [1:0] opt_wdt_in,
  input wire logic [1:0] opt_div_in,
  input wire logic       opt_filter_in,
  input wire logic       opt_rst_pin_in,
  input wire logic       opt_secure_in,
  input wire logic [1:0] opt_lv_in,
  input wire logic       sleep_in,
  input wire logic       slow_in,
  input wire logic       below_2v0_in,
  input wire logic       below_2v4_in,
  input wire logic       osc_pin_port_out,
  input wire logic       rst_pin_port_out,
  input wire logic       wdt_run_out,
  input wire logic       rom_protect_out,
  input wire logic       lv_reset_out,
  input wire logic       ind_3v6_en_out,
  input wire logic       cfg_err_out,
  input wire logic [1:0] div_eff_out,
  input wire logic       cyc_en_out
);
  // ----------------------------------------
  // options as held at the last reset edge
  // ----------------------------------------
  logic [1:0] hclk_q, wdt_q, div_q, lv_q;
  logic       filt_q, rpin_q, sec_q, run_q;
  logic       bad_pair;
  // later option changes must not reach the model either
  always_ff @(posedge clk_in) begin
    run_q <= !srst_in;
    if (srst_in) begin
      {hclk_q, wdt_q, div_q, lv_q} <= {opt_hclk_in, opt_wdt_in, opt_div_in, opt_lv_in};
      {filt_q, rpin_q, sec_q} <= {opt_filter_in, opt_rst_pin_in, opt_secure_in};
    end
  end
  assign bad_pair = filt_q && (div_q < `COCFG_DIV4);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // ----------------------------------------
  // static controls and cycle spacing
  // ----------------------------------------
  a_osc_pin_mode: assert property (run_q |-> osc_pin_port_out == (hclk_q == `COCFG_HCLK_RC))
    else $error("osc pin mode wrong");
  a_wdt_run_policy: assert property (run_q |-> wdt_run_out == (wdt_q == `COCFG_WDT_ALWAYS ||
    (wdt_q == `COCFG_WDT_ENABLE && !$past(sleep_in)))) else $error("watchdog run wrong");
  a_filter_clash: assert property (run_q |-> cfg_err_out == bad_pair)
    else $error("filter clash flag wrong");
  a_div_in_force: assert property (run_q |-> div_eff_out == (bad_pair ? `COCFG_DIV4 : div_q))
    else $error("divider in force wrong");
  a_reset_pin: assert property (run_q |-> rst_pin_port_out == !rpin_q)
    else $error("reset pin mode wrong");
  a_rom_guard: assert property (run_q |-> rom_protect_out == sec_q)
    else $error("rom protection wrong");
  a_lv_chip_reset: assert property (run_q |-> lv_reset_out == ((lv_q >= `COCFG_LV_HIGH) ?
    $past(below_2v4_in) : $past(below_2v0_in))) else $error("low voltage reset wrong");
  a_high_indicator: assert property (run_q |-> ind_3v6_en_out == (lv_q == `COCFG_LV_HIGH))
    else $error("3v6 indicator wrong");
  a_cycle_spacing: assert property (cyc_en_out && div_eff_out == `COCFG_DIV8 && !slow_in
    |=> !cyc_en_out [*7]) else $error("cycle pulse too early");
endmodule // cocfg_properties
bind cocfg_top cocfg_properties i_cocfg_properties (.clk_in, .srst_in, .opt_hclk_in,
  .opt_wdt_in, .opt_div_in, .opt_filter_in, .opt_rst_pin_in, .opt_secure_in, .opt_lv_in,
  .sleep_in, .slow_in, .below_2v0_in, .below_2v4_in, .osc_pin_port_out, .rst_pin_port_out,
  .wdt_run_out, .rom_protect_out, .lv_reset_out, .ind_3v6_en_out, .cfg_err_out,
  .div_eff_out, .cyc_en_out);
`default_nettype wire

// ===== tb/tb_cocfg_top.sv
// self-checking testbench for the code option loader
`timescale 1ns/1ps
`default_nettype none
`include "cocfg_consts.svh"
module tb_cocfg_top;
  import cocfg_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic       clk_in = 1'b0;
  logic       srst_in = 1'b1;
  logic [1:0] hclk = 2'h0, wdt = 2'h0, div = 2'h0, lv = 2'h0, tcnt = 2'h0;
  logic       filt = 1'b0, rpin = 1'b0, sec = 1'b0, sleep = 1'b0;
  logic       slow = 1'b0, tick = 1'b0, b20 = 1'b0, b24 = 1'b0;
  logic [3:0] bank = 4'h0;
  logic [7:0] addr = 8'h00;
  logic       osc, rpp, pull, wrun, rom, lvr, i24, i36, err, cyc;
  logic [1:0] deff;
  cocfg_rgn_e rgn;
  int         err_total = 0;
  int         checked = 0;
  always #5 clk_in = ~clk_in;
  // low clock tick every third cycle, free running
  always @(negedge clk_in) begin
    tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
    tick <= (tcnt == 2'h2);
  end
  cocfg_top i_cocfg_top (.clk_in(clk_in), .srst_in(srst_in), .opt_hclk_in(hclk),
    .opt_wdt_in(wdt), .opt_div_in(div), .opt_filter_in(filt), .opt_rst_pin_in(rpin),
    .opt_secure_in(sec), .opt_lv_in(lv), .sleep_in(sleep), .slow_in(slow),
    .slow_tick_in(tick), .below_2v0_in(b20), .below_2v4_in(b24), .bank_in(bank),
    .addr_in(addr), .osc_pin_port_out(osc), .rst_pin_port_out(rpp),
    .port0_bit2_pull_out(pull), .wdt_run_out(wrun), .rom_protect_out(rom),
    .lv_reset_out(lvr), .ind_2v4_en_out(i24), .ind_3v6_en_out(i36), .cfg_err_out(err),
    .div_eff_out(deff), .cyc_en_out(cyc), .rgn_out(rgn));
  // ----------------------------------------
  // compare, closing and helper tasks
  // ----------------------------------------
  task automatic cb(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cv(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // load options under reset, then invert the two-bit ones once running
  task automatic cfg(input logic [1:0] h, w, d, l, input logic f, r, s);
    @(negedge clk_in);
    srst_in = 1'b1;
    {hclk, wdt, div, lv, filt, rpin, sec} = {h, w, d, l, f, r, s};
    {sleep, slow, b20, b24} = 4'h0;
    repeat (8) @(negedge clk_in);
    cb("protect in reset", 1'b1, rom);
    cb("cycle in reset", 1'b0, cyc);
    srst_in = 1'b0;
    @(negedge clk_in);
    {hclk, wdt, div, lv} = ~{h, w, d, l};
  endtask
  // cycles between two instruction pulses, bounded wait
  task automatic gap(input int n);
    int c;
    c = 0;
    while (cyc !== 1'b1 && c < 40) begin
      @(negedge clk_in);
      c++;
    end
    c = 0;
    do begin
      @(negedge clk_in);
      c++;
    end while (cyc !== 1'b1 && c < 40);
    cv("cycle gap", n[7:0], c[7:0]);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rc_mid;
    cfg(`COCFG_HCLK_RC, `COCFG_WDT_ALWAYS, `COCFG_DIV8, `COCFG_LV_MID, 1'b0, 1'b0, 1'b1);
    {sleep, b20} = 2'h3;
    @(negedge clk_in);
    cb("osc pin", 1'b1, osc);
    cb("rst pin", 1'b1, rpp);
    cb("pull-up", 1'b0, pull);
    cb("wdt asleep", 1'b1, wrun);
    cb("protect", 1'b1, rom);
    cb("lv reset", 1'b1, lvr);
    cb("2v4 ind", 1'b1, i24);
    cv("divider", 8'h03, {6'h00, deff});
    gap(8);
  endtask
  task automatic t_xtal_high;
    cfg(`COCFG_HCLK_X12M, `COCFG_WDT_ENABLE, `COCFG_DIV1, `COCFG_LV_HIGH, 1'b1, 1'b1, 1'b0);
    b20 = 1'b1;
    @(negedge clk_in);
    cb("osc pin", 1'b0, osc);
    cb("rst pin", 1'b0, rpp);
    cb("wdt awake", 1'b1, wrun);
    cb("protect", 1'b0, rom);
    cb("clash", 1'b1, err);
    cv("divider", 8'h02, {6'h00, deff});
    cb("lv 2v0", 1'b0, lvr);
    cb("3v6 ind", 1'b1, i36);
    cb("2v4 ind", 1'b0, i24);
    {sleep, b24} = 2'h3;
    @(negedge clk_in);
    cb("wdt asleep", 1'b0, wrun);
    cb("lv 2v4", 1'b1, lvr);
    gap(4);
  endtask
  task automatic t_low_slow;
    cfg(`COCFG_HCLK_X4M, `COCFG_WDT_DISABLE, `COCFG_DIV2, `COCFG_LV_LOW, 1'b0, 1'b1, 1'b0);
    b24 = 1'b1;
    @(negedge clk_in);
    cb("wdt off", 1'b0, wrun);
    cb("clash", 1'b0, err);
    cb("lv 2v4", 1'b0, lvr);
    cb("2v4 ind", 1'b0, i24);
    cb("3v6 ind", 1'b0, i36);
    b20 = 1'b1;
    @(negedge clk_in);
    cb("lv 2v0", 1'b1, lvr);
    gap(2);
    slow = 1'b1;
    repeat (20) @(negedge clk_in);
    gap(12);
  endtask
  // hardened setting: filter on, always-on watchdog, spare level code
  task automatic t_noisy;
    cfg(`COCFG_HCLK_X4M, `COCFG_WDT_ALWAYS, `COCFG_DIV4, 2'h3, 1'b1, 1'b1, 1'b0);
    {sleep, b20} = 2'h3;
    @(negedge clk_in);
    cb("wdt asleep", 1'b1, wrun);
    cb("clash", 1'b0, err);
    cv("divider", 8'h02, {6'h00, deff});
    cb("lv code 3 2v0", 1'b0, lvr);
    cb("2v4 ind", 1'b0, i24);
    cb("3v6 ind", 1'b0, i36);
    b24 = 1'b1;
    @(negedge clk_in);
    cb("lv code 3 2v4", 1'b1, lvr);
    gap(4);
  endtask
  // unfiltered divide-by-1: a pulse on every clock
  task automatic t_fast;
    cfg(`COCFG_HCLK_RC, `COCFG_WDT_DISABLE, `COCFG_DIV1, `COCFG_LV_LOW, 1'b0, 1'b0, 1'b0);
    @(negedge clk_in);
    cb("clash", 1'b0, err);
    cv("divider", 8'h00, {6'h00, deff});
    gap(1);
  endtask
  // table of bank, address and region at the map edges
  task automatic t_map;
    logic [15:0] tbl [8];
    tbl = '{16'h0002, 16'h07F2, 16'h0804, 16'h0FF4, 16'hF008, 16'hF1F8, 16'hF201, 16'h1001};
    foreach (tbl[i]) begin
      @(negedge clk_in);
      {bank, addr} = tbl[i][15:4];
      #1;
      cv("region", {4'h0, tbl[i][3:0]}, {4'h0, rgn});
    end
  endtask
  initial begin
    t_rc_mid;
    t_xtal_high;
    t_low_slow;
    t_noisy;
    t_fast;
    t_map;
    test_done;
  end
  // watchdog: the run needs under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    err_total++;
    test_done;
  end
endmodule // tb_cocfg_top
`default_nettype wire
